// ===== ebra_top.sv
// Purpose: external bus cycle control with ready wait states and hold arbitration
// Assumes: inputs synchronous to clk_i; software starts accesses through Wishbone
// Notes: all sequencing advances on rising clock output edges
`timescale 1ns/1ns
module ebra_top
	import ebra_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ready_n_i,
	input wire logic hold_n_i,
	input wire logic [CS_W-1:0] cs_sel_i,
	output logic clock_output_pin_o,
	output logic cmd_n_o,
	output logic cmd_write_o,
	output logic ale_o,
	output logic [CS_W-1:0] chip_select_lines_o,
	output logic [CS_W-1:0] chip_select_lines_oe_n_o,
	output logic bus_oe_n_o,
	output logic bus_grant_ack_o,
	output logic bus_regain_request_n_o,
	output logic cycle_done_o
);
	ebra_state_t state;
	logic rise;
	logic [7:0] ctrl;
	logic pending;
	logic pend_we;
	logic [CTRL_WAIT_W-1:0] wait_cnt;
	logic [31:0] cycle_count;
	logic [31:0] ready_waits;
	logic bus_start;
	logic wb_req;
	logic wb_wr;
	logic done_evt;

	ebra_clk_div i_ebra_clk_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clock_output_pin_o(clock_output_pin_o),
		.rise_o(rise)
	);

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// register writes land on the ack edge
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign bus_start = wb_wr && (wb_adr_i == ADDR_ACCESS) && wb_sel_i[0];
	assign done_evt = rise && (state == ST_SAMPLE) && !ready_n_i;

	// wishbone ack one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= READ_ZERO;
		end else if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				ADDR_CTRL: wb_dat_o <= {24'h00_0000, ctrl};
				ADDR_STATUS: wb_dat_o <= {ready_waits[15:0], cycle_count[11:0],
					pending, bus_grant_ack_o, !bus_regain_request_n_o,
					state != ST_IDLE};
				default: wb_dat_o <= READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RESET;
		end else if (wb_wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
			ctrl <= wb_dat_i[7:0];
		end
	end

	// access request, a start while pending is ignored, completion clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pending <= 1'b0;
			pend_we <= 1'b0;
		end else if (bus_start && !pending) begin
			pending <= 1'b1;
			pend_we <= wb_dat_i[0];
		end else if (done_evt) begin
			pending <= 1'b0;
		end
	end

	// bus cycle and arbitration sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			wait_cnt <= '0;
		end else if (rise) begin
			case (state)
				ST_IDLE: begin
					if (!hold_n_i && ctrl[CTRL_HOLD_EN_BIT]) begin
						state <= ST_RELEASE;
					end else if (pending) begin
						state <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					wait_cnt <= ctrl[CTRL_WAIT_LSB +: CTRL_WAIT_W];
					state <= ctrl[CTRL_DELAY_BIT] ? ST_DELAY : ST_WAITS;
				end
				ST_DELAY: state <= ST_WAITS;
				ST_WAITS: begin
					if (wait_cnt == '0) begin
						state <= ST_SAMPLE;
					end else begin
						wait_cnt <= wait_cnt - 1'b1;
					end
				end
				ST_SAMPLE: begin
					if (!ready_n_i) begin
						state <= ctrl[CTRL_MUX_BIT] ? ST_MUXW : ST_IDLE;
					end
				end
				ST_MUXW: state <= ctrl[CTRL_TRI_BIT] ? ST_TRIW : ST_IDLE;
				ST_TRIW: state <= ST_IDLE;
				ST_RELEASE: state <= ST_HELD;
				ST_HELD: begin
					if (hold_n_i) begin
						state <= ST_REGAIN;
					end
				end
				ST_REGAIN: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ready wait state counter, stays in sampling state while high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_waits <= '0;
			cycle_count <= '0;
		end else if (rise && state == ST_SAMPLE) begin
			if (ready_n_i) begin
				ready_waits <= ready_waits + 32'h0000_0001;
			end else begin
				cycle_count <= cycle_count + 32'h0000_0001;
			end
		end
	end

	// bus pin outputs from flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ale_o <= 1'b0;
			cmd_n_o <= 1'b1;
			cmd_write_o <= 1'b0;
			chip_select_lines_o <= CS_IDLE;
		end else begin
			ale_o <= (state == ST_ADDR);
			cmd_n_o <= !(state == ST_WAITS || state == ST_SAMPLE);
			cmd_write_o <= pend_we;
			if (state == ST_ADDR || state == ST_DELAY || state == ST_WAITS
				|| state == ST_SAMPLE) begin
				chip_select_lines_o <= ~cs_sel_i;
			end else begin
				chip_select_lines_o <= CS_IDLE;
			end
		end
	end

	// termination pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cycle_done_o <= 1'b0;
		end else begin
			cycle_done_o <= done_evt;
		end
	end

	// grant, float and regain request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_grant_ack_o <= 1'b0;
			bus_oe_n_o <= 1'b0;
			chip_select_lines_oe_n_o <= '0;
			bus_regain_request_n_o <= 1'b1;
		end else if (rise) begin
			if (state == ST_RELEASE) begin
				bus_grant_ack_o <= 1'b1;
				bus_oe_n_o <= 1'b1;
				chip_select_lines_oe_n_o <= '1;
			end else if (state == ST_REGAIN) begin
				bus_grant_ack_o <= 1'b0;
				bus_oe_n_o <= 1'b0;
				chip_select_lines_oe_n_o <= '0;
			end
			bus_regain_request_n_o <= !(state == ST_HELD && pending && !hold_n_i);
		end
	end
endmodule

// ===== ebra_pkg.sv
// Purpose: constants for the external bus ready and hold arbiter
// Assumes: 100 MHz system clock, clock output runs at half rate
// Notes: register offsets for classic Wishbone access
package ebra_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int HALF_CLOCK_PERIOD_NS = 10;
	localparam int HALF_CLOCK_CYCLES = (HALF_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_ACCESS = 4'h8;
	localparam int CTRL_WAIT_LSB = 0;
	localparam int CTRL_WAIT_W = 4;
	localparam int CTRL_DELAY_BIT = 4;
	localparam int CTRL_MUX_BIT = 5;
	localparam int CTRL_TRI_BIT = 6;
	localparam int CTRL_HOLD_EN_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
	localparam logic [4:0] CS_IDLE = 5'h1f;
	localparam int CS_W = 5;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_DELAY, ST_WAITS, ST_SAMPLE, ST_MUXW, ST_TRIW, ST_RELEASE,
		ST_HELD, ST_REGAIN
	} ebra_state_t;
endpackage

// ===== ebra_clk_div.sv
// Purpose: divides the system clock into clock output phases
// Assumes: clock output period is two half clock periods
// Notes: rise_o marks the rising clock output edge
`timescale 1ns/1ns
module ebra_clk_div
	import ebra_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	output logic clock_output_pin_o,
	output logic rise_o
);
	logic [3:0] cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 4'h0;
			clock_output_pin_o <= 1'b0;
		end else if (cnt == 4'(HALF_CLOCK_CYCLES - 1)) begin
			cnt <= 4'h0;
			clock_output_pin_o <= ~clock_output_pin_o;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	assign rise_o = (cnt == 4'(HALF_CLOCK_CYCLES - 1)) && !clock_output_pin_o;
endmodule

// ===== ebra_checker.sv
// Purpose: bus cycle and hold handshake checks
// Assumes: sees top ports only
// Notes: bound at foot of file
`timescale 1ns/1ns
module ebra_checker
	import ebra_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ready_n_i,
	input wire logic hold_n_i,
	input wire logic clock_output_pin_o,
	input wire logic cmd_n_o,
	input wire logic [CS_W-1:0] chip_select_lines_oe_n_o,
	input wire logic bus_oe_n_o,
	input wire logic bus_grant_ack_o,
	input wire logic bus_regain_request_n_o,
	input wire logic cycle_done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_rdy_wait; (!cmd_n_o && ready_n_i)[*3] |=> !cmd_n_o; endproperty
	property p_done; cycle_done_o |-> ##[0:2] cmd_n_o; endproperty
	property p_idle_grant; $rose(bus_grant_ack_o) |-> cmd_n_o && $past(cmd_n_o); endproperty
	property p_cs_float; bus_grant_ack_o |-> chip_select_lines_oe_n_o == CS_IDLE; endproperty
	property p_keep; (!hold_n_i && bus_grant_ack_o)[*4] |=> bus_grant_ack_o; endproperty
	property p_give; $rose(hold_n_i) && bus_grant_ack_o |-> ##[1:8] !bus_grant_ack_o; endproperty
	property p_float; bus_grant_ack_o |-> bus_oe_n_o; endproperty
	property p_req; !bus_regain_request_n_o |-> bus_grant_ack_o; endproperty
	property p_clock_output_pin;
		!$past(rst_i) |-> clock_output_pin_o != $past(clock_output_pin_o);
	endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("early end");
	a_done: assert property (p_done) else $error("strobe kept");
	a_idle_grant: assert property (p_idle_grant) else $error("grant mid cycle");
	a_cs_float: assert property (p_cs_float) else $error("cs driven");
	a_keep: assert property (p_keep) else $error("bus taken early");
	a_give: assert property (p_give) else $error("bus not regained");
	a_float: assert property (p_float) else $error("bus driven");
	a_req: assert property (p_req) else $error("stray request");
	a_clock_output_pin: assert property (p_clock_output_pin) else $error("clock output stuck");
	c_grant: cover property ($rose(bus_grant_ack_o));
	c_done: cover property (cycle_done_o);
	c_req: cover property (!bus_regain_request_n_o);
endmodule
bind ebra_top ebra_checker i_ebra_checker(.clk_i(clk_i), .rst_i(rst_i), .ready_n_i(ready_n_i),
	.hold_n_i(hold_n_i), .clock_output_pin_o(clock_output_pin_o), .cmd_n_o(cmd_n_o),
	.chip_select_lines_oe_n_o(chip_select_lines_oe_n_o),
	.bus_oe_n_o(bus_oe_n_o), .bus_grant_ack_o(bus_grant_ack_o),
	.bus_regain_request_n_o(bus_regain_request_n_o), .cycle_done_o(cycle_done_o));

// ===== ebra_partner.sv
// Purpose: external responder answering with ready
// Assumes: delay_i plus one clocks from strobe to ready
// Notes: ready released once the strobe ends
`timescale 1ns/1ns
module ebra_partner(
	input wire logic clk_i,
	input wire logic cmd_n_i,
	input wire logic [3:0] delay_i,
	output logic ready_n_o
);
	logic [3:0] cnt = 4'h0;
	initial ready_n_o = 1'b1;
	always @(posedge clk_i) begin
		if (cmd_n_i) begin
			cnt <= 4'h0;
			ready_n_o <= 1'b1;
		end else if (cnt >= delay_i) begin
			ready_n_o <= 1'b0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// ===== ebra_top_test.sv
// Purpose: self-checking bench for the bus arbiter
// Assumes: partner answers with ready
// Notes: wishbone tasks drive all traffic
`timescale 1ns/1ns
module ebra_top_test;
	import ebra_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, hold_n, rdy_n, cmd_n, grant, req_n, done, oe_n;
	logic cmd_wr, ale;
	logic [3:0] adr, dly;
	logic [31:0] wdat, rdat;
	logic [CS_W-1:0] cs_oe_n, cs, csel;
	logic [7:0] cfg [5] = '{8'h00, 8'h03, 8'h11, 8'h20, 8'h62};
	int fail_count, tests_run, ticks, n, low, hi, lead;
	ebra_top i_ebra_top(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ready_n_i(rdy_n), .hold_n_i(hold_n), .cs_sel_i(csel),
		.clock_output_pin_o(), .cmd_n_o(cmd_n), .cmd_write_o(cmd_wr), .ale_o(ale),
		.chip_select_lines_o(cs), .chip_select_lines_oe_n_o(cs_oe_n), .bus_oe_n_o(oe_n),
		.bus_grant_ack_o(grant), .bus_regain_request_n_o(req_n), .cycle_done_o(done));
	ebra_partner i_ebra_partner(.clk_i(clk_i), .cmd_n_i(cmd_n), .delay_i(dly), .ready_n_o(rdy_n));
	task automatic final_report();
		if (fail_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		{cyc, stb, we} <= 3'b000;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 20000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		{rst_i, cyc, stb, we, hold_n, adr, wdat, dly} = {5'b10001, 4'h0, 32'h0000_0000, 4'h0};
		csel = 5'h01;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, ADDR_CTRL, 32'h0000_0000);
		chk(rdat, {24'h00_0000, CTRL_RESET});
		wb(1'b0, 4'hc, 32'h0000_ffff);
		chk(rdat, READ_ZERO);
		foreach (cfg[i]) begin
			wb(1'b1, ADDR_CTRL, {24'h00_0000, cfg[i]});
			dly <= (i % 2) ? 4'h7 : 4'h0;
			csel <= 5'h01 << i;
			wb(1'b1, ADDR_ACCESS, i % 2);
			low = 0;
			hi = 0;
			lead = 0;
			for (n = 0; n < 300 && done !== 1'b1; n++) begin
				@(posedge clk_i);
				if (ale === 1'b1) hi++;
				if (hi > 0 && low == 0 && ale === 1'b0 && cmd_n === 1'b1) lead++;
				if (cmd_n === 1'b0) begin
					low++;
					chk(cs, {~csel});
				end
			end
			chk(done, 1'b1);
			chk(low >= 2 * (cfg[i][3:0] + 1), 1);
			chk(hi, 2);
			chk(lead, 2 * cfg[i][4]);
			chk(cmd_wr, i % 2);
			n = 0;
			do begin
				wb(1'b0, ADDR_STATUS, 32'h0000_0000);
				n++;
			end while (rdat[0] !== 1'b0);
			chk(n, (cfg[i][5] && cfg[i][6]) ? 2 : 1);
			chk(cs, CS_IDLE);
		end
		chk(rdat[15:4], 12'h005);
		chk(rdat[31:16] != 16'h0000, 1);
		wb(1'b1, ADDR_CTRL, 32'h0000_0080);
		hold_n <= 1'b0;
		for (n = 0; n < 100 && grant !== 1'b1; n++) @(posedge clk_i);
		chk(cs_oe_n, CS_IDLE);
		chk(oe_n, 1'b1);
		hold_n <= 1'b1;
		for (n = 0; n < 100 && grant !== 1'b0; n++) @(posedge clk_i);
		chk({grant, oe_n}, 2'b00);
		dly <= 4'h8;
		wb(1'b1, ADDR_ACCESS, 32'h0000_0000);
		for (n = 0; n < 100 && cmd_n !== 1'b0; n++) @(posedge clk_i);
		hold_n <= 1'b0;
		low = 0;
		for (n = 0; n < 100 && grant !== 1'b1; n++) begin
			@(posedge clk_i);
			if (done === 1'b1) low = 1;
		end
		chk(low, 1);
		wb(1'b1, ADDR_ACCESS, 32'h0000_0001);
		for (n = 0; n < 100 && req_n !== 1'b0; n++) @(posedge clk_i);
		chk(req_n, 1'b0);
		repeat (10) @(posedge clk_i);
		chk(grant, 1'b1);
		hold_n <= 1'b1;
		for (n = 0; n < 200 && done !== 1'b1; n++) @(posedge clk_i);
		chk({done, req_n, grant}, 3'b110);
		final_report();
	end
endmodule
